// ===== hdl/spi_master_pkg.sv
// Shared constants and types of the serial bus master engine
package spi_master_pkg;

	// **********************************************************************
	// Widths and depths
	// **********************************************************************
	localparam int WORD_W     = 16;
	localparam int LEN_W      = 16;
	localparam int DIV_W      = 16;
	localparam int FIFO_DEPTH = 8;

	// **********************************************************************
	// Rates: link kernel clock and default serial clock, in Hz
	// **********************************************************************
	localparam int unsigned LINK_CLK_HZ     = 33_333_333;
	localparam int unsigned BAUD_DEFAULT_HZ = 1_000_000;

	// **********************************************************************
	// Values after reset and defaults
	// **********************************************************************
	localparam logic [4:0] BITS_DEFAULT = 5'h08;
	localparam logic [4:0] BITS_MAX     = 5'h10;
	localparam logic [7:0] FILL_DEFAULT = 8'h00;
	localparam logic       CPOL_RESET   = 1'b0;
	localparam logic       CPHA_RESET   = 1'b0;
	localparam logic       LSB_RESET    = 1'b0;

	// **********************************************************************
	// Types
	// **********************************************************************
	typedef enum logic [1:0] {
		OP_READ   = 2'b00,
		OP_WRITE  = 2'b01,
		OP_DUPLEX = 2'b10
	} op_e;

	typedef enum logic [2:0] {
		S_IDLE    = 3'b000,
		S_LOAD    = 3'b001,
		S_WAIT    = 3'b010,
		S_DELIVER = 3'b011
	} sys_state_e;

	typedef struct packed {
		logic             cpol;
		logic             cpha;
		logic             lsb_first;
		logic [4:0]       bits;
		logic [DIV_W-1:0] half_div;
	} cfg_s;

	typedef struct packed {
		cfg_s              cfg;
		logic [WORD_W-1:0] word;
	} xfer_s;

	typedef struct packed {
		op_e              op;
		logic [LEN_W-1:0] len;
		logic             use_fill;
		logic [7:0]       fill;
	} cmd_s;

	// Half period of the serial clock in link cycles, rounded up so the
	// real rate never exceeds the one asked for
	function automatic logic [DIV_W-1:0] half_div_for(input int unsigned baud_hz);
		int unsigned h;
		h = (LINK_CLK_HZ + 2 * baud_hz - 1) / (2 * baud_hz);
		if (h == 0) begin
			h = 1;
		end
		return DIV_W'(h);
	endfunction

endpackage

// ===== hdl/spi_word_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module spi_word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               cnt;
		logic                        in_ready;
		logic                        out_valid;
	} fifo_s;

	fifo_s f;
	fifo_s next_f;
	logic  push;
	logic  pop;

	// **********************************************************************
	// Pointers and flags
	// **********************************************************************
	always_comb begin
		next_f = f;
		push   = in_valid_i & f.in_ready;
		pop    = out_ready_i & f.out_valid;
		if (push) begin
			next_f.mem[f.wr] = in_data_i;
			next_f.wr = (f.wr == PW'(DEPTH - 1)) ? '0 : PW'(f.wr + 1'b1);
		end
		if (pop) begin
			next_f.rd = (f.rd == PW'(DEPTH - 1)) ? '0 : PW'(f.rd + 1'b1);
		end
		if (push && !pop) begin
			next_f.cnt = CW'(f.cnt + 1'b1);
		end else if (pop && !push) begin
			next_f.cnt = CW'(f.cnt - 1'b1);
		end
		// Flags are registered so full and empty never glitch at the ports
		next_f.in_ready  = (next_f.cnt != CW'(DEPTH));
		next_f.out_valid = (next_f.cnt != '0);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			f          <= '0;
			f.in_ready <= 1'b1;
		end else begin
			f <= next_f;
		end
	end

	assign in_ready_o  = f.in_ready;
	assign out_valid_o = f.out_valid;
	assign out_data_o  = f.mem[f.rd];

endmodule // spi_word_fifo

`default_nettype wire

// ===== hdl/spi_master_engine.sv
// Serial bus master engine: command side on clk_i, shifter on link_clk_i
//
// Operation
// RULE1 - Only this master drives the serial clock and starts every transfer.
// RULE2 - Serial clock rate is configurable; default rate is 1000000 Hz.
// RULE3 - Idle serial clock rests at polarity level: low for 0, high for 1.
// RULE4 - Phase 0 samples on first clock edge of a bit, phase 1 on second.
// RULE5 - Word width is configurable; 8 bits always supported, here 1 to 16.
// RULE6 - Bit order selects MSB or LSB first, on both data lines.
// RULE7 - Read clocks exactly the asked count, sending fill byte, default 0x00.
// RULE8 - Read-to-buffer clocks buffer length, sending fill, storing bytes in order.
// RULE9 - Write shifts out every supplied word in order; received words dropped.
// RULE10 - Full duplex sends and receives equal counts; requester supplies one length.
// RULE11 - Slave selects are driven by outside logic; no select here.
// RULE12 - Opening without new settings keeps the last initialised settings.
// RULE13 - Shutdown stops the bus; no clocking until initialised again. Here open_i also restarts clocking without init.
// RULE14 - Busy from transfer start to last sample; done pulses one cycle. Here busy holds until done, after the last word is acknowledged or delivered.
`timescale 1ns/1ps
`default_nettype none

module spi_master_engine #(
	parameter int unsigned BAUD_HZ = spi_master_pkg::BAUD_DEFAULT_HZ
) (
	input  wire logic                               clk_i,
	input  wire logic                               rstn_i,
	input  wire logic                               link_clk_i,
	input  wire logic                               init_i,
	input  wire spi_master_pkg::cfg_s               cfg_i,
	input  wire logic                               open_i,
	input  wire logic                               shutdown_i,
	input  wire logic                               cmd_valid_i,
	input  wire spi_master_pkg::cmd_s               cmd_i,
	output logic                                    cmd_ready_o,
	input  wire logic                               tx_valid_i,
	input  wire logic [spi_master_pkg::WORD_W-1:0]  tx_data_i,
	output logic                                    tx_ready_o,
	output logic                                    rx_valid_o,
	output logic      [spi_master_pkg::WORD_W-1:0]  rx_data_o,
	input  wire logic                               rx_ready_i,
	output logic                                    busy_o,
	output logic                                    done_o,
	output logic                                    enabled_o,
	output logic                                    sck_o,
	output logic                                    mosi_o,
	input  wire logic                               miso_i
);

	localparam logic [spi_master_pkg::DIV_W-1:0] DEF_DIV = spi_master_pkg::half_div_for(BAUD_HZ);

	// **********************************************************************
	// State types
	// **********************************************************************
	typedef struct packed {
		spi_master_pkg::sys_state_e          st;
		logic                                en;
		spi_master_pkg::cfg_s                cfg;
		spi_master_pkg::op_e                 op;
		logic [spi_master_pkg::LEN_W-1:0]    left;
		logic [spi_master_pkg::WORD_W-1:0]   fill;
		spi_master_pkg::xfer_s               xfer;
		logic                                req_tog;
		logic [2:0]                          ack_s;
		logic                                rx_valid;
		logic [spi_master_pkg::WORD_W-1:0]   rx_data;
		logic                                busy;
		logic                                done;
		logic                                cmd_ready;
	} sys_s;

	typedef struct packed {
		logic [2:0]                          req_s;
		logic [2:0]                          cpol_s;
		logic [2:0]                          miso_s;
		logic                                miso_f;
		logic                                cpol_f;
		logic                                active;
		logic                                sck;
		logic                                mosi;
		logic                                ack_tog;
		logic [spi_master_pkg::DIV_W-1:0]    div;
		logic [5:0]                          edge_cnt;
		spi_master_pkg::cfg_s                cfg;
		logic [spi_master_pkg::WORD_W-1:0]   tx;
		logic [spi_master_pkg::WORD_W-1:0]   rx;
		logic [spi_master_pkg::WORD_W-1:0]   rx_word;
	} link_s;

	sys_s                               s;
	sys_s                               next_s;
	link_s                              l;
	link_s                              next_l;
	logic [2:0]                         link_rst_s;
	logic                               link_rstn;
	logic                               fifo_valid;
	logic [spi_master_pkg::WORD_W-1:0]  fifo_data;
	logic                               fifo_pop;
	logic [4:0]                         bit_idx;
	logic [4:0]                         bit_nxt;
	logic                               leading;

	// **********************************************************************
	// Helpers
	// **********************************************************************
	function automatic logic [3:0] bit_pos(input logic [4:0] idx, input logic [4:0] bits,
			input logic lsb);
		return lsb ? idx[3:0] : 4'(bits - 5'h01 - idx); // [RULE6]
	endfunction

	function automatic spi_master_pkg::cfg_s cfg_fix(input spi_master_pkg::cfg_s c);
		spi_master_pkg::cfg_s r;
		r = c;
		if (c.bits == 5'h00 || c.bits > spi_master_pkg::BITS_MAX) begin
			r.bits = spi_master_pkg::BITS_DEFAULT; // [RULE5]
		end
		if (c.half_div == '0) begin
			r.half_div = DEF_DIV; // [RULE2]
		end
		return r;
	endfunction

	// **********************************************************************
	// Transmit FIFO
	// **********************************************************************
	spi_word_fifo #(
		.WIDTH (spi_master_pkg::WORD_W),
		.DEPTH (spi_master_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (tx_valid_i),
		.in_data_i   (tx_data_i),
		.in_ready_o  (tx_ready_o),
		.out_valid_o (fifo_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (fifo_pop)
	);

	// **********************************************************************
	// Command side, clk_i domain
	// **********************************************************************
	always_comb begin
		next_s       = s;
		next_s.done  = 1'b0;
		next_s.ack_s = {s.ack_s[1:0], l.ack_tog};
		fifo_pop     = 1'b0;
		if (shutdown_i) begin
			next_s.en = 1'b0; // [RULE13]
		end
		case (s.st)
			spi_master_pkg::S_IDLE: begin
				if (!shutdown_i) begin
					if (init_i) begin
						next_s.cfg = cfg_fix(cfg_i);
						next_s.en  = 1'b1;
					end else if (open_i) begin
						next_s.en = 1'b1; // [RULE12]
					end else if (cmd_valid_i && s.cmd_ready) begin
						next_s.op   = cmd_i.op;
						next_s.left = cmd_i.len; // [RULE10]
						next_s.fill = spi_master_pkg::WORD_W'(cmd_i.use_fill ? cmd_i.fill
							: spi_master_pkg::FILL_DEFAULT); // [RULE7]
						if (cmd_i.len == '0) begin
							next_s.done = 1'b1;
						end else begin
							next_s.busy = 1'b1; // [RULE14]
							next_s.st   = spi_master_pkg::S_LOAD; // [RULE1]
						end
					end
				end
			end
			spi_master_pkg::S_LOAD: begin
				if (!s.en) begin
					// A shutdown ends the command at a word boundary
					next_s.st   = spi_master_pkg::S_IDLE; // [RULE13]
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end else if (s.op == spi_master_pkg::OP_READ) begin
					next_s.xfer.cfg  = s.cfg;
					next_s.xfer.word = s.fill; // [RULE7] [RULE8]
					next_s.req_tog   = ~s.req_tog;
					next_s.st        = spi_master_pkg::S_WAIT;
				end else if (fifo_valid) begin
					fifo_pop         = 1'b1;
					next_s.xfer.cfg  = s.cfg;
					next_s.xfer.word = fifo_data; // [RULE9] [RULE10]
					next_s.req_tog   = ~s.req_tog;
					next_s.st        = spi_master_pkg::S_WAIT;
				end
			end
			spi_master_pkg::S_WAIT: begin
				if (s.ack_s[2] == s.ack_s[1] && s.ack_s[2] == s.req_tog) begin
					next_s.left = spi_master_pkg::LEN_W'(s.left - 1'b1);
					if (s.op == spi_master_pkg::OP_WRITE) begin
						if (s.left == spi_master_pkg::LEN_W'(1)) begin
							next_s.st   = spi_master_pkg::S_IDLE; // [RULE9]
							next_s.busy = 1'b0;
							next_s.done = 1'b1; // [RULE14]
						end else begin
							next_s.st = spi_master_pkg::S_LOAD;
						end
					end else begin
						next_s.rx_valid = 1'b1; // [RULE7] [RULE8] [RULE10]
						next_s.rx_data  = l.rx_word;
						next_s.st       = spi_master_pkg::S_DELIVER;
					end
				end
			end
			spi_master_pkg::S_DELIVER: begin
				// A slow reader stalls the bus between words, never loses one
				if (rx_ready_i) begin
					next_s.rx_valid = 1'b0;
					if (s.left == '0) begin
						next_s.st   = spi_master_pkg::S_IDLE;
						next_s.busy = 1'b0;
						next_s.done = 1'b1; // [RULE14]
					end else begin
						next_s.st = spi_master_pkg::S_LOAD;
					end
				end
			end
			default: begin
				next_s.st = spi_master_pkg::S_IDLE;
			end
		endcase
		next_s.cmd_ready = (next_s.st == spi_master_pkg::S_IDLE) && next_s.en && !next_s.done;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s                <= '0;
			s.cfg.cpol       <= spi_master_pkg::CPOL_RESET;
			s.cfg.cpha       <= spi_master_pkg::CPHA_RESET;
			s.cfg.lsb_first  <= spi_master_pkg::LSB_RESET;
			s.cfg.bits       <= spi_master_pkg::BITS_DEFAULT;
			s.cfg.half_div   <= DEF_DIV; // [RULE2]
			s.fill           <= spi_master_pkg::WORD_W'(spi_master_pkg::FILL_DEFAULT);
		end else begin
			s <= next_s;
		end
	end

	// **********************************************************************
	// Link side, link_clk_i domain
	// **********************************************************************
	always_ff @(posedge link_clk_i) begin
		link_rst_s <= {link_rst_s[1:0], rstn_i};
	end
	assign link_rstn = link_rst_s[2];

	always_comb begin
		next_l        = l;
		next_l.req_s  = {l.req_s[1:0], s.req_tog};
		next_l.cpol_s = {l.cpol_s[1:0], s.cfg.cpol};
		next_l.miso_s = {l.miso_s[1:0], miso_i};
		bit_idx       = l.edge_cnt[5:1];
		bit_nxt       = 5'(bit_idx + 5'h01);
		leading       = ~l.edge_cnt[0];
		// Three-flop filtering costs a few link cycles of MISO setup per half bit
		if (l.miso_s[1] == l.miso_s[2]) begin
			next_l.miso_f = l.miso_s[2];
		end
		if (l.cpol_s[1] == l.cpol_s[2]) begin
			next_l.cpol_f = l.cpol_s[2];
		end
		if (!l.active) begin
			next_l.sck = l.cpol_f; // [RULE3]
			if (l.req_s[1] == l.req_s[2] && l.req_s[2] != l.ack_tog) begin
				next_l.active   = 1'b1; // [RULE1]
				next_l.cfg      = s.xfer.cfg;
				next_l.tx       = s.xfer.word;
				next_l.rx       = '0;
				next_l.div      = '0;
				next_l.edge_cnt = '0;
				next_l.sck      = s.xfer.cfg.cpol; // [RULE3]
				if (!s.xfer.cfg.cpha) begin
					next_l.mosi = s.xfer.word[bit_pos(5'h00, s.xfer.cfg.bits,
						s.xfer.cfg.lsb_first)]; // [RULE4] [RULE6]
				end
			end
		end else begin
			next_l.div = spi_master_pkg::DIV_W'(l.div + 1'b1);
			if (next_l.div == l.cfg.half_div) begin // [RULE2]
				next_l.div = '0;
				if (l.edge_cnt == {l.cfg.bits, 1'b0}) begin
					// Last half period gives the slave hold time before release
					next_l.active  = 1'b0; // [RULE5]
					next_l.ack_tog = ~l.ack_tog;
					next_l.rx_word = l.rx;
				end else begin
					next_l.sck      = ~l.sck; // [RULE1]
					next_l.edge_cnt = 6'(l.edge_cnt + 6'h01);
					if (leading != l.cfg.cpha) begin
						next_l.rx[bit_pos(bit_idx, l.cfg.bits, l.cfg.lsb_first)] =
							l.miso_f; // [RULE4] [RULE6]
					end else if (l.cfg.cpha) begin
						next_l.mosi = l.tx[bit_pos(bit_idx, l.cfg.bits,
							l.cfg.lsb_first)]; // [RULE4]
					end else if (bit_nxt < l.cfg.bits) begin
						next_l.mosi = l.tx[bit_pos(bit_nxt, l.cfg.bits,
							l.cfg.lsb_first)]; // [RULE6]
					end
				end
			end
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (!link_rstn) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// **********************************************************************
	// Outputs; no slave select is made here, outside logic owns it [RULE11]
	// **********************************************************************
	assign cmd_ready_o = s.cmd_ready;
	assign rx_valid_o  = s.rx_valid;
	assign rx_data_o   = s.rx_data;
	assign busy_o      = s.busy; // [RULE14]
	assign done_o      = s.done;
	assign enabled_o   = s.en;
	assign sck_o       = l.sck;
	assign mosi_o      = l.mosi;

endmodule // spi_master_engine

`default_nettype wire

// ===== testbench/spi_master_engine_sva.sv
// Concurrent checks on the serial master engine ports
`timescale 1ns/1ps
`default_nettype none

module spi_master_engine_sva #(
	parameter int unsigned BAUD_HZ = spi_master_pkg::BAUD_DEFAULT_HZ
) (
	input wire logic                              clk_i,
	input wire logic                              rstn_i,
	input wire logic                              init_i,
	input wire spi_master_pkg::cfg_s              cfg_i,
	input wire logic                              open_i,
	input wire logic                              shutdown_i,
	input wire logic                              cmd_valid_i,
	input wire spi_master_pkg::cmd_s              cmd_i,
	input wire logic                              cmd_ready_o,
	input wire logic                              rx_valid_o,
	input wire logic [spi_master_pkg::WORD_W-1:0] rx_data_o,
	input wire logic                              rx_ready_i,
	input wire logic                              busy_o,
	input wire logic                              done_o,
	input wire logic                              enabled_o,
	input wire logic                              sck_o
);
	// ****************
	// Helper state
	// ****************
	logic                cpol_q;
	logic [3:0]          quiet;
	spi_master_pkg::op_e op_q;

	// Idle level is only judged once the new polarity had time to cross over
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cpol_q <= 1'b0;
			quiet <= 4'h0;
			op_q <= spi_master_pkg::OP_READ;
		end else begin
			if (init_i && !busy_o && !shutdown_i) begin
				cpol_q <= cfg_i.cpol;
			end
			if (init_i || busy_o) begin
				quiet <= 4'h0;
			end else if (quiet != 4'hF) begin
				quiet <= quiet + 4'h1;
			end
			if (cmd_valid_i && cmd_ready_o) begin
				op_q <= cmd_i.op;
			end
		end
	end

	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_take;
		cmd_valid_i && cmd_ready_o && !shutdown_i && !init_i && !open_i;
	endsequence

	property p_start;
		s_take ##0 (cmd_i.len != 16'h0000) |=> busy_o && !cmd_ready_o;
	endproperty
	a_start: assert property (p_start) else $error("busy missing after start");
	property p_zero;
		s_take ##0 (cmd_i.len == 16'h0000) |=> done_o && !busy_o;
	endproperty
	a_zero: assert property (p_zero) else $error("empty command misbehaved");
	property p_end;
		$fell(busy_o) |-> done_o;
	endproperty
	a_end: assert property (p_end) else $error("busy fell without done");
	property p_pulse;
		done_o |=> !done_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
	property p_busy_ready;
		busy_o |-> !cmd_ready_o;
	endproperty
	a_busy_ready: assert property (p_busy_ready) else $error("ready while busy");
	property p_off_ready;
		!enabled_o |-> !cmd_ready_o;
	endproperty
	a_off_ready: assert property (p_off_ready) else $error("ready while off");
	property p_idle_sck;
		(quiet == 4'hF) |-> (sck_o == cpol_q);
	endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("idle clock level wrong");
	property p_off_still;
		(!enabled_o && !busy_o) [*4] |-> $stable(sck_o);
	endproperty
	a_off_still: assert property (p_off_still) else $error("clock moved while off");
	property p_rx_hold;
		rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");
	property p_write_quiet;
		busy_o && (op_q == spi_master_pkg::OP_WRITE) |-> !rx_valid_o;
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("rx during write");
endmodule // spi_master_engine_sva

bind spi_master_engine spi_master_engine_sva #(.BAUD_HZ(BAUD_HZ)) u_sva (
	.clk_i(clk_i), .rstn_i(rstn_i), .init_i(init_i), .cfg_i(cfg_i), .open_i(open_i),
	.shutdown_i(shutdown_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
	.cmd_ready_o(cmd_ready_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
	.rx_ready_i(rx_ready_i), .busy_o(busy_o), .done_o(done_o), .enabled_o(enabled_o),
	.sck_o(sck_o)
);
`default_nettype wire

// ===== testbench/spi_slave_model.sv
// Behavioural serial slave answering the engine
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	input  wire logic        cpol_i,
	input  wire logic        cpha_i,
	input  wire logic        lsb_i,
	input  wire logic [4:0]  bits_i,
	input  wire logic [15:0] resp_i,
	input  wire logic        clr_i
);
	// No select input: framing is left to outside logic
	logic [15:0] got [16];
	logic [15:0] sh = 16'h0000;
	logic [15:0] tw;
	int          cnt = 0;
	int          oi = 0;
	int          wc = 0;

	function automatic int pos(input int i, input logic l, input logic [4:0] b);
		return l ? i : int'(b) - 1 - i;
	endfunction

	// Each word answered differs, so order faults show
	assign tw = resp_i + 16'(wc);
	// Outside a word the line shows noise, not the last bit
	assign miso_o = (oi >= 0 && oi < int'(bits_i)) ? tw[pos(oi, lsb_i, bits_i)] : !mosi_i;

	task automatic finish_word(input int nx);
		got[wc % 16] = sh;
		sh = 16'h0000;
		wc++;
		cnt = 0;
		oi = nx;
	endtask

	always @(posedge clr_i) begin
		sh = 16'h0000;
		cnt = 0;
		wc = 0;
		oi = cpha_i ? -1 : 0;
	end

	// Sample on leading edge for phase 0, trailing for phase 1
	always @(sck_i) begin
		if ((sck_i != cpol_i) ^ cpha_i) begin
			sh[pos(cnt, lsb_i, bits_i)] = mosi_i;
			cnt++;
			if (cpha_i && cnt == int'(bits_i)) begin
				finish_word(-1);
			end
		end else if (cnt == int'(bits_i)) begin
			finish_word(0);
		end else begin
			oi++;
		end
	end
endmodule // spi_slave_model
`default_nettype wire

// ===== testbench/spi_master_engine_tb_top.sv
// Self-checking bench for the serial master engine
`timescale 1ns/1ps
`default_nettype none

module spi_master_engine_tb_top;
	// ****************
	// Signals
	// ****************
	localparam int CEIL = 20000;
	logic                 clk_i = 1'b0;
	logic                 link_clk = 1'b0;
	logic                 rstn_i, init, open, shut, cmd_valid, tx_valid, rx_ready, clr;
	logic                 cmd_ready, tx_ready, rx_valid, busy, done, enabled, sck, mosi, miso;
	spi_master_pkg::cfg_s cfg;
	spi_master_pkg::cmd_s cmd;
	logic [15:0]          tx_data, rx_data, resp, mk;
	logic [15:0]          rxq [$];
	logic [4:0]           bl [4] = '{5'h08, 5'h05, 5'h10, 5'h08};
	int                   err_count = 0;
	int                   n_checks = 0;
	int                   cyc = 0;
	realtime              t0 = 0;
	realtime              hp = 0;

	always #50 clk_i = ~clk_i;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end
	always @(sck) begin
		hp = $realtime - t0;
		t0 = $realtime;
	end
	always @(posedge clk_i) begin
		if (rstn_i && rx_valid === 1'b1 && rx_ready === 1'b1) begin
			rxq.push_back(rx_data);
		end
	end

	spi_master_engine dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk), .init_i(init), .cfg_i(cfg),
		.open_i(open), .shutdown_i(shut), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.cmd_ready_o(cmd_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rx_ready_i(rx_ready), .busy_o(busy), .done_o(done), .enabled_o(enabled),
		.sck_o(sck), .mosi_o(mosi), .miso_i(miso)
	);
	spi_slave_model slv (
		.sck_i(sck), .mosi_i(mosi), .miso_o(miso), .cpol_i(cfg.cpol), .cpha_i(cfg.cpha),
		.lsb_i(cfg.lsb_first), .bits_i(cfg.bits), .resp_i(resp), .clr_i(clr)
	);

	// ****************
	// Tasks
	// ****************
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == CEIL) begin
			err_count++;
			$display("[FAIL] %0t run too long", $time);
			wrap_up();
		end
	end
	task automatic step();
		@(posedge clk_i);
		#10;
	endtask
	task automatic chk(logic [15:0] g, logic [15:0] e, string w);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
		end
	endtask
	task automatic do_init(logic p, logic h, logic l, logic [4:0] b, logic [15:0] d);
		cfg = '{p, h, l, b, d};
		mk = 16'((17'h00001 << b) - 17'h00001);
		init = 1'b1;
		step();
		init = 1'b0;
		repeat (4) step();
	endtask
	task automatic push_n(int n);
		tx_valid = 1'b1;
		for (int k = 0; k < n; k++) begin
			tx_data = (16'hA3C5 >> k) & mk;
			step();
		end
		tx_valid = 1'b0;
	endtask
	task automatic run(spi_master_pkg::op_e op, logic [15:0] len, logic fe, logic [7:0] fv);
		int i;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 100) begin
			step();
			i++;
		end
		rxq.delete();
		clr = 1'b1;
		cmd_valid = 1'b1;
		cmd = '{op, len, fe, fv};
		step();
		cmd_valid = 1'b0;
		clr = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 3000) begin
			step();
			i++;
		end
		chk(16'(done), 16'h0001, "done");
		step();
	endtask
	task automatic chk_words(int n, logic rx_on);
		for (int k = 0; k < n; k++) begin
			chk(slv.got[k], (16'hA3C5 >> k) & mk, "mosi word");
			if (rx_on) begin
				chk(rxq[k], (resp + 16'(k)) & mk, "rx word");
			end
		end
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		{rstn_i, init, open, shut, cmd_valid, tx_valid, clr} = 7'h00;
		rx_ready = 1'b1;
		cfg = '0;
		cmd = '0;
		tx_data = 16'h0000;
		resp = 16'h3C5A;
		mk = 16'h00FF;
		repeat (16) @(posedge clk_i);
		#10;
		rstn_i = 1'b1;
		step();
		chk(16'({enabled, cmd_ready, sck}), 16'h0000, "after reset");
		for (int m = 0; m < 4; m++) begin
			do_init(m[1], m[0], m[0] ^ m[1], bl[m], (m == 3) ? 16'h0000 : 16'h0008);
			chk(16'(sck), 16'(m[1]), "idle level");
			push_n(3);
			run(spi_master_pkg::OP_DUPLEX, 16'h0003, 1'b0, 8'h00);
			chk(16'(rxq.size()), 16'h0003, "rx count");
			chk_words(3, 1'b1);
			chk(16'(sck), 16'(m[1]), "idle after");
		end
		// Rate may fall short of the default by one link cycle, never exceed it
		chk(16'(hp >= 5.0e8 / spi_master_pkg::BAUD_DEFAULT_HZ
			&& hp < 5.0e8 / spi_master_pkg::BAUD_DEFAULT_HZ + 30.0), 16'h0001, "half period");
		run(spi_master_pkg::OP_READ, 16'h0002, 1'b1, 8'hA5);
		chk(slv.got[1], 16'h00A5, "fill");
		chk(16'(rxq.size()), 16'h0002, "read count");
		chk(rxq[1], (resp + 16'h0001) & mk, "read order");
		run(spi_master_pkg::OP_READ, 16'h0001, 1'b0, 8'hA5);
		chk(slv.got[0], 16'h0000, "default fill");
		run(spi_master_pkg::OP_READ, 16'h0000, 1'b0, 8'h00);
		chk(16'(rxq.size()), 16'h0000, "empty read");
		push_n(8);
		chk(16'(tx_ready), 16'h0000, "fifo full");
		run(spi_master_pkg::OP_WRITE, 16'h0008, 1'b0, 8'h00);
		chk(16'(rxq.size()), 16'h0000, "write rx");
		chk_words(8, 1'b0);
		rx_ready = 1'b0;
		fork
			run(spi_master_pkg::OP_READ, 16'h0002, 1'b0, 8'h00);
			begin
				repeat (300) step();
				chk(16'({rx_valid, busy}), 16'h0003, "stall");
				rx_ready = 1'b1;
			end
		join
		chk(16'(rxq.size()), 16'h0002, "after stall");
		shut = 1'b1;
		step();
		shut = 1'b0;
		cmd_valid = 1'b1;
		cmd = '{spi_master_pkg::OP_READ, 16'h0001, 1'b0, 8'h00};
		repeat (20) step();
		cmd_valid = 1'b0;
		chk(16'({enabled, cmd_ready, busy}), 16'h0000, "shut");
		chk(16'(sck), 16'(cfg.cpol), "shut clock");
		open = 1'b1;
		step();
		open = 1'b0;
		step();
		chk(16'(enabled), 16'h0001, "open");
		push_n(1);
		run(spi_master_pkg::OP_DUPLEX, 16'h0001, 1'b0, 8'h00);
		chk_words(1, 1'b1);
		wrap_up();
	end
endmodule // spi_master_engine_tb_top
`default_nettype wire
